// ---- hw/dmc_engine.sv ----
// eight channel data mover, checksum unit, bus bridge, service requests
// assumes one clock for the register bus and all three master ports
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "dmc_map.svh"
// Operation
// - eight independent channels in one group
// - per-channel trigger chosen from eight inputs
// - two-level priority set per channel
// - start by software or hardware request
// - single mode clears enable at count end
// - continuous mode keeps enable, reloads count
// - 32-bit addresses with programmable modification
// - circular buffer wrap within programmed region
// - move width of 8, 16 or 32 bits
// - per-channel source, destination, control, count registers
// - switch to system, dedicated and link buses
// - link interface also reaches checksum unit
// - one pending move buffered per bus
// - group priority programmable per bus port
// - bridge host accesses; dedicated bus shared with channels
// - channel and link service request outputs
// - each input write updates checksum result
// - checksum uses 32-bit Ethernet polynomial
module dmc_engine (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] hwReq,
    input wire logic [3:0] linkEvt,
    output logic [7:0] srChan,
    output logic [3:0] srLink,
    output logic sysReq,
    output logic sysWrite,
    output logic [31:0] sysAddr,
    output logic [31:0] sysWdata,
    output logic [1:0] sysSize,
    output logic [1:0] sysPrio,
    input wire logic sysAck,
    input wire logic [31:0] sysRdata,
    output logic dedReq,
    output logic dedWrite,
    output logic [31:0] dedAddr,
    output logic [31:0] dedWdata,
    output logic [1:0] dedSize,
    output logic [1:0] dedPrio,
    input wire logic dedAck,
    input wire logic [31:0] dedRdata,
    output logic linkReq,
    output logic linkWrite,
    output logic [31:0] linkAddr,
    output logic [31:0] linkWdata,
    output logic [1:0] linkSize,
    output logic [1:0] linkPrio,
    input wire logic linkAck,
    input wire logic [31:0] linkRdata
);
    // -----------------------------------------------------------
    // helpers
    // -----------------------------------------------------------
    // msb-first fold of one word into the signature
    function automatic dmc_pkg::dmc_word_t crcFold(
        input dmc_pkg::dmc_word_t c, input dmc_pkg::dmc_word_t d);
        dmc_pkg::dmc_word_t r;
        r = c;
        for (int i = 0; i < 32; i++) begin
            r = (r[31] ^ d[31 - i]) ? ({r[30:0], 1'b0} ^ `DMC_CRC_POLY)
                : {r[30:0], 1'b0};
        end
        return r;
    endfunction : crcFold
    // wrap inside a 2^size byte region when circular mode is set
    function automatic dmc_pkg::dmc_word_t stepAddr(
        input dmc_pkg::dmc_word_t a, input logic inc, input logic circ,
        input logic [3:0] size, input logic [1:0] w);
        dmc_pkg::dmc_word_t lin;
        dmc_pkg::dmc_word_t msk;
        lin = a + (inc ? (32'h0000_0001 << w) : 32'h0000_0000);
        msk = (32'h0000_0001 << size) - 32'h0000_0001;
        return circ ? ((a & ~msk) | (lin & msk)) : lin;
    endfunction : stepAddr
    // select code 3 is folded onto the system bus
    function automatic logic [1:0] busOf(input logic [1:0] s);
        return (s == 2'b11) ? 2'b00 : s;
    endfunction : busOf
    // -----------------------------------------------------------
    // storage
    // -----------------------------------------------------------
    logic [31:0] srcAddr_reg [8];
    logic [31:0] dstAddr_reg [8];
    logic [31:0] ctrl_reg [8];
    logic [15:0] cnt_reg [8];
    logic [15:0] reload_reg [8];
    logic [7:0] trig_reg;
    logic [7:0] done_reg;
    logic [7:0] srChan_reg;
    logic [3:0] srLink_reg;
    logic [3:0] srnEn_reg;
    logic [5:0] busPrio_reg;
    logic [31:0] chkRes_reg;
    logic [31:0] aAddr_reg;
    logic aWrite_reg;
    logic dph_reg;
    logic bridgeSent_reg;
    logic [31:0] hrdata_reg;
    logic hready_reg;
    logic [2:0] pReq_reg;
    logic [2:0] pWr_reg;
    logic [2:0] pEng_reg;
    logic [31:0] pAddr_reg [3];
    logic [31:0] pWdata_reg [3];
    logic [1:0] pSize_reg [3];
    dmc_pkg::dmc_state_e state_reg;
    logic [2:0] ch_reg;
    logic [31:0] data_reg;
    // -----------------------------------------------------------
    // register bus decode
    // -----------------------------------------------------------
    wire accept = hsel & htrans[1] & hready;
    wire aBridge = aAddr_reg[`DMC_BRIDGE_BIT];
    wire chWin = ~aBridge & ~aAddr_reg[7];
    wire [2:0] aCh = aAddr_reg[6:4];
    wire [3:0] aOff = aAddr_reg[3:0];
    wire [7:0] aLow = aAddr_reg[7:0];
    wire regWr = dph_reg & aWrite_reg & ~aBridge;
    wire wrChk = regWr & (aLow == `DMC_CHK_IN);
    wire wrRes = regWr & (aLow == `DMC_CHK_RES);
    wire wrCtrl = regWr & chWin & (aOff == `DMC_CH_CTRL);
    wire bridgeLoad = dph_reg & aBridge & ~bridgeSent_reg & ~pReq_reg[1];
    wire bridgeDone = dph_reg & aBridge & bridgeSent_reg & pReq_reg[1]
        & ~pEng_reg[1] & dedAck;
    wire [31:0] ctrlRd = (ctrl_reg[aCh] & `DMC_CTRL_MASK)
        | ({31'h0000_0000, trig_reg[aCh]} << `DMC_C_BUSY);
    // read mux; unmapped words read zero
    wire [31:0] rdMux =
        (chWin && aOff == `DMC_CH_SRC) ? srcAddr_reg[aCh] :
        (chWin && aOff == `DMC_CH_DST) ? dstAddr_reg[aCh] :
        (chWin && aOff == `DMC_CH_CTRL) ? ctrlRd :
        (chWin && aOff == `DMC_CH_CNT) ? {reload_reg[aCh], cnt_reg[aCh]} :
        (aLow == `DMC_CHK_RES) ? chkRes_reg :
        (aLow == `DMC_BUS_PRIO) ? {26'h000_0000, busPrio_reg} :
        (aLow == `DMC_SRN_EN) ? {28'h000_0000, srnEn_reg} :
        (aLow == `DMC_DONE) ? {24'h00_0000, done_reg} : `DMC_WORD_ZERO;
    // -----------------------------------------------------------
    // arbitration and engine decode
    // -----------------------------------------------------------
    logic [7:0] pend;
    logic [7:0] hiPend;
    logic [2:0] pick;
    logic anyPend;
    // lowest index wins within a level; high level first
    always_comb begin
        pick = 3'h0;
        for (int i = 0; i < 8; i++) begin
            pend[i] = ctrl_reg[i][`DMC_C_EN] & trig_reg[i]
                & (cnt_reg[i] != 16'h0000);
            hiPend[i] = pend[i] & ctrl_reg[i][`DMC_C_HIPRI];
        end
        for (int i = 7; i >= 0; i--) begin
            if (pend[i]) begin
                pick = 3'(i);
            end
        end
        for (int i = 7; i >= 0; i--) begin
            if (hiPend[i]) begin
                pick = 3'(i);
            end
        end
        anyPend = |pend;
    end
    wire [31:0] cur = ctrl_reg[ch_reg];
    wire [1:0] width = cur[`DMC_C_WIDTH];
    wire [1:0] sBus = busOf(cur[`DMC_C_SBUS]);
    wire [1:0] dBus = busOf(cur[`DMC_C_DBUS]);
    wire [31:0] wMask = (width == 2'b00) ? 32'h0000_00FF :
        (width == 2'b01) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    wire [2:0] portFree = ~pReq_reg & {1'b1, ~bridgeLoad, 1'b1};
    wire toChk = (dBus == 2'b10)
        && (dstAddr_reg[ch_reg] == `DMC_CHK_LINK_ADDR);
    wire engChk = (state_reg == dmc_pkg::ENG_WRITE) & toChk & ~wrChk;
    wire engRd = (state_reg == dmc_pkg::ENG_READ) & portFree[sBus];
    wire engWr = (state_reg == dmc_pkg::ENG_WRITE) & ~toChk
        & portFree[dBus];
    wire [31:0] ackRd = (sBus == 2'b00) ? sysRdata :
        (sBus == 2'b01) ? dedRdata : linkRdata;
    wire [2:0] ackIn = {linkAck, dedAck, sysAck};
    wire rdDone = (state_reg == dmc_pkg::ENG_RWAIT) & ackIn[sBus]
        & pReq_reg[sBus] & pEng_reg[sBus];
    wire finish = (state_reg == dmc_pkg::ENG_UPDATE)
        & (cnt_reg[ch_reg] == 16'h0001);
    // -----------------------------------------------------------
    // register bus slave
    // -----------------------------------------------------------
    // one wait state per register access keeps read data coming from a flop
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            aAddr_reg <= `DMC_WORD_ZERO;
            aWrite_reg <= 1'b0;
            dph_reg <= 1'b0;
            bridgeSent_reg <= 1'b0;
            hrdata_reg <= `DMC_WORD_ZERO;
            hready_reg <= 1'b1;
        end else if (accept) begin
            aAddr_reg <= haddr;
            aWrite_reg <= hwrite;
            dph_reg <= 1'b1;
            hready_reg <= 1'b0;
        end else if (dph_reg && !aBridge) begin
            hrdata_reg <= aWrite_reg ? `DMC_WORD_ZERO : rdMux;
            hready_reg <= 1'b1;
            dph_reg <= 1'b0;
        end else if (bridgeLoad) begin
            bridgeSent_reg <= 1'b1;
        end else if (bridgeDone) begin
            hrdata_reg <= aWrite_reg ? `DMC_WORD_ZERO : dedRdata;
            hready_reg <= 1'b1;
            dph_reg <= 1'b0;
            bridgeSent_reg <= 1'b0;
        end
    end
    // -----------------------------------------------------------
    // global registers, checksum, service requests
    // -----------------------------------------------------------
    // set wins over clear on the done flags
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            chkRes_reg <= `DMC_CHK_INIT;
            busPrio_reg <= 6'h00;
            srnEn_reg <= 4'h0;
            done_reg <= 8'h00;
            srChan_reg <= 8'h00;
            srLink_reg <= 4'h0;
        end else begin
            if (wrChk) begin
                chkRes_reg <= crcFold(chkRes_reg, hwdata);
            end else if (engChk) begin
                chkRes_reg <= crcFold(chkRes_reg, data_reg);
            end else if (wrRes) begin
                chkRes_reg <= hwdata;
            end
            if (regWr && aLow == `DMC_BUS_PRIO) begin
                busPrio_reg <= hwdata[5:0];
            end
            if (regWr && aLow == `DMC_SRN_EN) begin
                srnEn_reg <= hwdata[3:0];
            end
            done_reg <= ((regWr && aLow == `DMC_DONE) ?
                done_reg & ~hwdata[7:0] : done_reg)
                | (finish ? (8'h01 << ch_reg) : 8'h00);
            srChan_reg <= (finish && cur[`DMC_C_SREN]) ?
                (8'h01 << ch_reg) : 8'h00;
            srLink_reg <= linkEvt & srnEn_reg;
        end
    end
    // -----------------------------------------------------------
    // channel registers
    // -----------------------------------------------------------
    // engine update first, a same-cycle software write overrides it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                srcAddr_reg[i] <= `DMC_WORD_ZERO;
                dstAddr_reg[i] <= `DMC_WORD_ZERO;
                ctrl_reg[i] <= `DMC_WORD_ZERO;
                cnt_reg[i] <= 16'h0000;
                reload_reg[i] <= 16'h0000;
            end
            trig_reg <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (state_reg == dmc_pkg::ENG_UPDATE && ch_reg == 3'(i)) begin
                    srcAddr_reg[i] <= stepAddr(srcAddr_reg[i],
                        cur[`DMC_C_SINC], cur[`DMC_C_SCIRC],
                        cur[`DMC_C_CSIZE], width);
                    dstAddr_reg[i] <= stepAddr(dstAddr_reg[i],
                        cur[`DMC_C_DINC], cur[`DMC_C_DCIRC],
                        cur[`DMC_C_CSIZE], width);
                    cnt_reg[i] <= cnt_reg[i] - 16'h0001;
                    if (finish && cur[`DMC_C_CONT]) begin
                        cnt_reg[i] <= reload_reg[i];
                    end else if (finish) begin
                        ctrl_reg[i][`DMC_C_EN] <= 1'b0;
                    end
                end
                if (regWr && chWin && aCh == 3'(i)) begin
                    unique case (aOff)
                        `DMC_CH_SRC: srcAddr_reg[i] <= hwdata;
                        `DMC_CH_DST: dstAddr_reg[i] <= hwdata;
                        `DMC_CH_CTRL: ctrl_reg[i] <= hwdata & `DMC_CTRL_MASK;
                        `DMC_CH_CNT: begin
                            cnt_reg[i] <= hwdata[15:0];
                            reload_reg[i] <= hwdata[15:0];
                        end
                        default: ;
                    endcase
                end
                // trigger set wins over the end-of-transaction clear
                trig_reg[i] <= (trig_reg[i]
                    & ~(finish && ch_reg == 3'(i)))
                    | (wrCtrl && aCh == 3'(i) && hwdata[`DMC_C_SWREQ])
                    | (ctrl_reg[i][`DMC_C_HWEN]
                    & hwReq[ctrl_reg[i][`DMC_C_TSEL]]);
            end
        end
    end
    // -----------------------------------------------------------
    // move engine
    // -----------------------------------------------------------
    // re-arbitrates after every move so a high level channel cuts in
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= dmc_pkg::ENG_IDLE;
            ch_reg <= 3'h0;
            data_reg <= `DMC_WORD_ZERO;
        end else begin
            unique case (state_reg)
                dmc_pkg::ENG_IDLE: if (anyPend) begin
                    ch_reg <= pick;
                    state_reg <= dmc_pkg::ENG_READ;
                end
                dmc_pkg::ENG_READ: if (engRd) begin
                    state_reg <= dmc_pkg::ENG_RWAIT;
                end
                dmc_pkg::ENG_RWAIT: if (rdDone) begin
                    data_reg <= ackRd & wMask;
                    state_reg <= dmc_pkg::ENG_WRITE;
                end
                dmc_pkg::ENG_WRITE: if (engChk || engWr) begin
                    state_reg <= dmc_pkg::ENG_UPDATE;
                end
                dmc_pkg::ENG_UPDATE: state_reg <= dmc_pkg::ENG_IDLE;
                default: state_reg <= dmc_pkg::ENG_IDLE;
            endcase
        end
    end
    // -----------------------------------------------------------
    // master ports, one buffered move each
    // -----------------------------------------------------------
    // a loaded move is held until its acknowledge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pReq_reg <= 3'h0;
            pWr_reg <= 3'h0;
            pEng_reg <= 3'h0;
            for (int p = 0; p < 3; p++) begin
                pAddr_reg[p] <= `DMC_WORD_ZERO;
                pWdata_reg[p] <= `DMC_WORD_ZERO;
                pSize_reg[p] <= 2'b00;
            end
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (pReq_reg[p] && ackIn[p]) begin
                    pReq_reg[p] <= 1'b0;
                end else if (p == 1 && bridgeLoad) begin
                    pReq_reg[p] <= 1'b1;
                    pEng_reg[p] <= 1'b0;
                    pWr_reg[p] <= aWrite_reg;
                    pAddr_reg[p] <= aAddr_reg;
                    pWdata_reg[p] <= hwdata;
                    pSize_reg[p] <= 2'b10;
                end else if ((engRd && sBus == 2'(p))
                    || (engWr && dBus == 2'(p))) begin
                    pReq_reg[p] <= 1'b1;
                    pEng_reg[p] <= 1'b1;
                    pWr_reg[p] <= engWr;
                    pAddr_reg[p] <= engWr ? dstAddr_reg[ch_reg]
                        : srcAddr_reg[ch_reg];
                    pWdata_reg[p] <= data_reg;
                    pSize_reg[p] <= width;
                end
            end
        end
    end
    // -----------------------------------------------------------
    // outputs
    // -----------------------------------------------------------
    assign hrdata = hrdata_reg;
    assign hreadyout = hready_reg;
    assign hresp = 1'b0;
    assign srChan = srChan_reg;
    assign srLink = srLink_reg;
    assign {linkReq, dedReq, sysReq} = pReq_reg;
    assign {linkWrite, dedWrite, sysWrite} = pWr_reg;
    assign sysAddr = pAddr_reg[0];
    assign dedAddr = pAddr_reg[1];
    assign linkAddr = pAddr_reg[2];
    assign sysWdata = pWdata_reg[0];
    assign dedWdata = pWdata_reg[1];
    assign linkWdata = pWdata_reg[2];
    assign sysSize = pSize_reg[0];
    assign dedSize = pSize_reg[1];
    assign linkSize = pSize_reg[2];
    assign {linkPrio, dedPrio, sysPrio} = busPrio_reg;
    // -----------------------------------------------------------
    // assertions
    // -----------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_chk_fold: assert property (wrChk |=>
        chkRes_reg == crcFold($past(chkRes_reg), $past(hwdata)))
        else $error("checksum not folded");
    a_chk_reload: assert property (wrRes && !wrChk |=>
        chkRes_reg == $past(hwdata)) else $error("checksum not reloaded");
    a_single_stop: assert property (finish && !cur[`DMC_C_CONT] |=>
        !ctrl_reg[$past(ch_reg)][`DMC_C_EN] || $past(wrCtrl))
        else $error("single mode left enabled");
    a_cont_keep: assert property (finish && cur[`DMC_C_CONT]
        && !wrCtrl |=> ctrl_reg[$past(ch_reg)][`DMC_C_EN])
        else $error("continuous mode dropped enable");
    a_prio_pick: assert property (state_reg == dmc_pkg::ENG_IDLE
        && (|hiPend) |=> ctrl_reg[ch_reg][`DMC_C_HIPRI])
        else $error("low level chosen over high");
    a_ded_hold: assert property (dedReq && !dedAck |=>
        dedReq && $stable(dedAddr)) else $error("dedicated move lost");
    a_width_mask: assert property (engWr && width == 2'b00 |=>
        (sysReq || dedReq || linkReq) && data_reg[31:8] == 24'h00_0000)
        else $error("byte move carries upper bits");
    a_sr_pulse: assert property (finish && cur[`DMC_C_SREN] |=>
        srChan != 8'h00 ##1 srChan == 8'h00)
        else $error("service request not a pulse");
    a_sw_start: assert property (wrCtrl && hwdata[`DMC_C_SWREQ] |=>
        trig_reg[$past(aCh)]) else $error("software start lost");
    a_read_wait: assert property (accept |=> !hreadyout ##1
        (hreadyout || aBridge)) else $error("bus wait state wrong");
endmodule : dmc_engine
`default_nettype wire

// ---- hw/dmc_map.svh ----
// register offsets, control fields, reset values and constants of the
// eight channel data mover with memory checksum unit
// assumes a 32-bit word bus; every offset is a byte address
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
// ---------------------------------------------------------------
// address map
// ---------------------------------------------------------------
`define DMC_CH_SRC 4'h0
`define DMC_CH_DST 4'h4
`define DMC_CH_CTRL 4'h8
`define DMC_CH_CNT 4'hC
`define DMC_CHK_IN 8'h80
`define DMC_CHK_RES 8'h84
`define DMC_BUS_PRIO 8'h88
`define DMC_SRN_EN 8'h8C
`define DMC_DONE 8'h90
`define DMC_BRIDGE_BIT 12
`define DMC_CHK_LINK_ADDR 32'hF000_0000
// ---------------------------------------------------------------
// channel control fields
// ---------------------------------------------------------------
`define DMC_C_EN 0
`define DMC_C_CONT 1
`define DMC_C_HIPRI 2
`define DMC_C_HWEN 3
`define DMC_C_TSEL 6:4
`define DMC_C_WIDTH 8:7
`define DMC_C_SINC 9
`define DMC_C_DINC 10
`define DMC_C_SCIRC 11
`define DMC_C_DCIRC 12
`define DMC_C_CSIZE 16:13
`define DMC_C_SBUS 18:17
`define DMC_C_DBUS 20:19
`define DMC_C_SREN 21
`define DMC_C_SWREQ 24
`define DMC_C_BUSY 25
`define DMC_CTRL_MASK 32'h003F_FFFF
// ---------------------------------------------------------------
// reset values and checksum
// ---------------------------------------------------------------
`define DMC_CHK_INIT 32'hFFFF_FFFF
`define DMC_CRC_POLY 32'h04C1_1DB7
`define DMC_WORD_ZERO 32'h0000_0000
`endif

// ---- hw/dmc_pkg.sv ----
// types shared by the data mover design
// assumes the map header supplies all numeric constants
package dmc_pkg;
    // engine sequence states
    typedef enum logic [2:0] {
        ENG_IDLE = 3'b000,
        ENG_READ = 3'b001,
        ENG_RWAIT = 3'b010,
        ENG_WRITE = 3'b011,
        ENG_UPDATE = 3'b100
    } dmc_state_e;
    typedef logic [31:0] dmc_word_t;
endpackage : dmc_pkg

// ---- tb/dmc_bus_model.sv ----
// behavioural bus target standing on one master port of the mover
// assumes the engine holds a move request steady until the ack edge
`timescale 1ns/10ps
`default_nettype none
module dmc_bus_model #(parameter int DELAY = 1) (
    input wire logic sys_clk, // shared with the engine
    input wire logic req,
    input wire logic write,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    output logic ack,
    output logic [31:0] rdata
);
    logic [3:0] waitCnt = 4'h0;
    logic [31:0] lastAddr = 32'h0;
    logic [31:0] lastData = 32'h0;
    // one ack pulse after DELAY idle cycles; data lines toggle otherwise
    // so a late sample never sees a plausible word
    always_ff @(posedge sys_clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (req && !ack) begin
            waitCnt <= waitCnt + 4'h1;
            if (waitCnt >= DELAY[3:0]) begin
                ack <= 1'b1;
                waitCnt <= 4'h0;
                rdata <= addr ^ 32'hA5A5_A5A5;
                lastAddr <= write ? addr : lastAddr;
                lastData <= write ? wdata : lastData;
            end
        end
    end
endmodule : dmc_bus_model
`default_nettype wire

// ---- tb/dma_with_memory_checksum_test.sv ----
// self-checking bench for the data mover and its checksum unit
// assumes one 10 MHz clock and three behavioural bus targets
`timescale 1ns/10ps
`default_nettype none
`include "dmc_map.svh"
module dma_with_memory_checksum_test;
    logic sys_clk = 1'b0, reset = 1'b1, hsel = 1'b1, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp;
    logic [7:0] hwReq = 8'h0, srChan, srSeen = 8'h0;
    logic [3:0] linkEvt = 4'h0, srLink;
    logic sysReq, sysWrite, sysAck, dedReq, dedWrite, dedAck;
    logic linkReq, linkWrite, linkAck;
    logic [31:0] sysAddr, sysWdata, sysRdata, dedAddr, dedWdata, dedRdata;
    logic [31:0] linkAddr, linkWdata, linkRdata;
    logic [1:0] sysSize, sysPrio, dedSize, dedPrio, linkSize, linkPrio;
    int n_errors = 0, cmp_count = 0;
    assign hready = hreadyout;
    always #50 sys_clk = ~sys_clk;
    // sticky copy of the one-cycle channel requests
    always @(posedge sys_clk) begin
        if (!reset) srSeen <= srSeen | srChan;
    end
    dmc_engine DUT (.sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .hwReq,
        .linkEvt, .srChan, .srLink, .sysReq, .sysWrite, .sysAddr, .sysWdata,
        .sysSize, .sysPrio, .sysAck, .sysRdata, .dedReq, .dedWrite, .dedAddr,
        .dedWdata, .dedSize, .dedPrio, .dedAck, .dedRdata, .linkReq,
        .linkWrite, .linkAddr, .linkWdata, .linkSize, .linkPrio, .linkAck,
        .linkRdata);
    // prompt system bus, slow dedicated bus, middling link
    dmc_bus_model #(.DELAY(0)) SYS (.sys_clk, .req(sysReq), .write(sysWrite),
        .addr(sysAddr), .wdata(sysWdata), .ack(sysAck), .rdata(sysRdata));
    dmc_bus_model #(.DELAY(3)) DED (.sys_clk, .req(dedReq), .write(dedWrite),
        .addr(dedAddr), .wdata(dedWdata), .ack(dedAck), .rdata(dedRdata));
    dmc_bus_model #(.DELAY(1)) LNK (.sys_clk, .req(linkReq),
        .write(linkWrite), .addr(linkAddr), .wdata(linkWdata),
        .ack(linkAck), .rdata(linkRdata));
    task automatic chk(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one single AHB word transfer; waits on hready, never on a count
    task automatic bus(input logic w, input logic [31:0] a, wd);
        @(posedge sys_clk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge sys_clk iff hreadyout);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk iff hreadyout);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input string w, input logic [31:0] a, exp);
        bus(1'b0, a, 32'h0);
        chk(w, exp, rd);
    endtask : rdchk
    // reference fold, msb first, no reflection
    function automatic logic [31:0] fold(input logic [31:0] c, d);
        for (int i = 31; i >= 0; i--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `DMC_CRC_POLY : 32'h0);
        return c;
    endfunction : fold
    // program a channel, write its control word to start it, poll its done flag
    task automatic run(input logic [31:0] b, s, d, c);
        wr(b, s);
        wr(b + 32'h4, d);
        wr(b + 32'hC, 32'h1);
        wr(b + 32'h8, c);
        for (int n = 0; n < 40; n++) begin
            bus(1'b0, `DMC_DONE, 32'h0);
            if (rd[b[6:4]] === 1'b1) break;
        end
        chk("done flag", 32'h1, {31'h0, rd[b[6:4]]});
        @(posedge sys_clk iff !(sysReq || dedReq || linkReq));
    endtask : run
    task automatic t_reset;
        rdchk("chk result", `DMC_CHK_RES, `DMC_CHK_INIT);
        rdchk("unmapped", 32'h94, 32'h0);
        chk("hresp", 32'h0, {31'h0, hresp});
        $display("t_reset done");
    endtask : t_reset
    task automatic t_chk;
        logic [31:0] e;
        e = fold(fold(`DMC_CHK_INIT, 32'h1234_5678), 32'hFFFF_0000);
        wr(`DMC_CHK_IN, 32'h1234_5678);
        wr(`DMC_CHK_IN, 32'hFFFF_0000);
        rdchk("chk fold", `DMC_CHK_RES, e);
        wr(`DMC_CHK_RES, `DMC_CHK_INIT);
        rdchk("chk reload", `DMC_CHK_RES, `DMC_CHK_INIT);
        $display("t_chk done");
    endtask : t_chk
    task automatic t_single;
        run(32'h0, 32'h100, 32'h200, 32'h0128_0705);
        chk("chan node", 32'h1, {24'h0, srSeen});
        chk("ded data", 32'hA5A5_A4A5, DED.lastData);
        chk("ded addr", 32'h200, DED.lastAddr);
        rdchk("src word step", 32'h0, 32'h104);
        bus(1'b0, 32'h8, 32'h0);
        chk("single enable", 32'h0, {31'h0, rd[0]});
        $display("t_single done");
    endtask : t_single
    task automatic t_cont;
        run(32'h10, 32'h300, 32'h400, 32'h0110_0603);
        chk("link byte", 32'hA5, {24'h0, LNK.lastData[7:0]});
        chk("link addr", 32'h400, LNK.lastAddr);
        rdchk("src byte step", 32'h10, 32'h301);
        bus(1'b0, 32'h18, 32'h0);
        chk("cont enable", 32'h1, {31'h0, rd[0]});
        wr(32'h18, 32'h0);
        $display("t_cont done");
    endtask : t_cont
    task automatic t_srn;
        wr(`DMC_SRN_EN, 32'h5);
        @(posedge sys_clk);
        linkEvt <= 4'hF;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("link node", 32'h5, {28'h0, srLink});
        @(posedge sys_clk);
        linkEvt <= 4'h0;
        wr(`DMC_BUS_PRIO, 32'h39);
        chk("prio", 32'h39, {26'h0, linkPrio, dedPrio, sysPrio});
        $display("t_srn done");
    endtask : t_srn
    // hardware start, byte move into the checksum, circular source
    task automatic t_hwchk;
        hwReq <= 8'h20;
        run(32'h20, 32'h503, 32'hF000_0000, 32'h0010_4A59);
        hwReq <= 8'h00;
        rdchk("chk by chan", `DMC_CHK_RES, fold(`DMC_CHK_INIT, 32'hA6));
        chk("link untouched", 32'h400, LNK.lastAddr);
        rdchk("src circ wrap", 32'h20, 32'h500);
        $display("t_hwchk done");
    endtask : t_hwchk
    task automatic t_bridge;
        wr(32'h0000_1020, 32'h0000_BEEF);
        chk("bridge addr", 32'h1020, DED.lastAddr);
        chk("bridge data", 32'hBEEF, DED.lastData);
        rdchk("bridge read", 32'h1040, 32'h1040 ^ 32'hA5A5_A5A5);
        $display("t_bridge done");
    endtask : t_bridge
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_chk();
        t_single();
        t_cont();
        t_srn();
        t_hwchk();
        t_bridge();
        report_and_stop();
    end
    // watchdog: the whole run needs well under 20000 cycles
    initial begin
        #2000000;
        n_errors++;
        report_and_stop();
    end
endmodule : dma_with_memory_checksum_test
`default_nettype wire
